// ==== sim/lpc_ctrl_model.sv ====
/*
  Memory controller model: drives clock-enable and the command pins.
  Assumes clk_sys runs free and the bench calls its tasks in sequence.
*/
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl_model
  import lpc_pkg::*;
(
  input  wire logic     clk_sys,
  output var  logic     ckePin,
  output var  lpc_cmd_t cmdPin
);
  // Pins change 1 ns after an edge and hold for the whole cycle.
  task automatic drive(input logic cke, input logic [3:0] cmd, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      ckePin = cke;
      cmdPin = cmd;
    end
  endtask : drive

  // One low-power visit; the clock keeps running throughout.
  task automatic visit(input logic [3:0] cmd, input int stay, input int gap);
    drive(1'b0, cmd, 1);
    // Don't-care pins toggle every cycle so stale values cannot help.
    for (int i = 0; i < stay; i++) begin
      drive(1'b0, ~cmdPin, 1);
    end
    drive(1'b1, CMD_NOP, gap);
  endtask : visit

  // Idle bus until the first task runs.
  initial begin
    ckePin = 1'b1;
    cmdPin = CMD_NOP;
  end
endmodule : lpc_ctrl_model
`default_nettype wire

// ==== sim/lpc_power_ctrl_bench.sv ====
/*
  Self-checking bench for the low-power state control.
  Assumes the controller model drives pins; a state model predicts outputs.
*/
`timescale 1ns/1ns
`default_nettype none
module lpc_power_ctrl_bench
  import lpc_pkg::*;
;
  localparam int REFI = 8;
  logic        clk_sys;
  logic        rst;
  logic        allBanksIdle;
  logic        accessBusy;
  logic        ckePin;
  lpc_cmd_t    cmdPin;
  lpc_status_t status;
  lpc_state_t  powerState;
  logic        intRefreshPulse;
  logic        cmdAccept;
  int          errorCnt;
  int          cmpCount;
  int          st;
  int          cnt;
  int          rc;
  bit          lost;
  bit          apd;
  bit          exPulse;
  bit          ill;
  bit          acc;
  logic        ch [3];
  logic [3:0]  cq [3];
  logic [31:0] seed;

  lpc_power_ctrl #(.REFI_CYCLES(REFI)) lpc_power_ctrl_inst (
    .clk_sys(clk_sys), .rst(rst), .ckePin(ckePin), .cmdPin(cmdPin),
    .allBanksIdle(allBanksIdle), .accessBusy(accessBusy),
    .status(status), .powerState(powerState),
    .intRefreshPulse(intRefreshPulse), .cmdAccept(cmdAccept)
  );
  lpc_ctrl_model ctl (.clk_sys(clk_sys), .ckePin(ckePin), .cmdPin(cmdPin));

  // Free-running 50 MHz clock; it is never stopped or retuned, so the
  // clock-stop and frequency-change conditions are never entered.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic endOfTest;
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : endOfTest

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : cmp_bit

  task automatic cmp_state(input logic [2:0] got, input logic [2:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %0t state %0d exp %0d", $time, got, exp);
    end
  endtask : cmp_state

  // Reference model; pins reach the decision two edges after they change.
  // The internal timer refreshes once every REFI + 1 cycles in self refresh.
  always @(posedge clk_sys) begin
    exPulse = 1'b0;
    ill = 1'b0;
    acc = 1'b0;
    if (rst) begin
      st = 0;
      lost = 1'b0;
      ch = '{1'b1, 1'b1, 1'b1};
    end else begin
      case (st)
        0: if (ch[2] && !ch[1]) begin
          if (cq[1] == CMD_REFRESH && allBanksIdle) begin
            st = 2;
            exPulse = 1'b1;
            rc = REFI;
          end else if (cq[1] == CMD_BURST_END && allBanksIdle) begin
            st = 3;
            lost = 1'b1;
          end else if (cq[1] == CMD_NOP && !accessBusy) begin
            st = 1;
            apd = !allBanksIdle;
          end else begin
            ill = 1'b1;
          end
        end else if (!ch[2] && !ch[1]) begin
          ill = 1'b1;
        end else if (ch[2] && ch[1] && !cq[1][3] && cq[1] != CMD_NOP) begin
          acc = 1'b1;
        end
        1, 2: begin
          if (st == 2) begin
            if (rc == 0) begin
              exPulse = 1'b1;
              rc = REFI;
            end else begin
              rc--;
            end
          end
          if (ch[1] && (cq[1][3] || cq[1] == CMD_NOP)) begin
            cnt = (st == 2) ? SRX_CYC : XP_CYC;
            st = 4;
          end else if (ch[1]) begin
            ill = 1'b1;
          end
        end
        3: begin
          if (ch[1]) begin
            st = 0;
          end
        end
        default: begin
          if (!cq[1][3] && cq[1] != CMD_NOP) begin
            ill = 1'b1;
          end
          cnt--;
          if (cnt == 0) begin
            st = 0;
          end
        end
      endcase
    end
    ch[2] = ch[1];
    ch[1] = ch[0];
    ch[0] = ckePin;
    cq[2] = cq[1];
    cq[1] = cq[0];
    cq[0] = cmdPin;
  end

  // Outputs are registered, so they are settled by the falling edge.
  always @(negedge clk_sys) begin
    if (!rst) begin
      cmp_state(powerState, st[2:0]);
      cmp_bit(status.dataLost, lost, "data lost");
      cmp_bit(status.pumpsOn, st != 3, "pumps");
      cmp_bit(intRefreshPulse, exPulse, "refresh");
      cmp_bit(status.activePd, st == 1 && apd, "active pd");
      cmp_bit(status.bufEnable, st == 0 || st == 4, "buffers");
      cmp_bit(status.intClkEnable, st != 2, "int clock");
      cmp_bit(status.illegal, ill, "illegal");
      cmp_bit(cmdAccept, acc, "accept");
    end
  end

  // Hang guard well above the longest sequence, about 10000 cycles.
  initial begin
    #200000;
    errorCnt++;
    endOfTest();
  end

  // Alternate power-down and self refresh with random stays, then deep pd.
  initial begin
    rst = 1'b1;
    allBanksIdle = 1'b1;
    accessBusy = 1'b0;
    errorCnt = 0;
    cmpCount = 0;
    seed = 32'h86E70B36;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    ctl.drive(1'b1, CMD_NOP, 4);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      if (i % 2) begin
        ctl.visit(CMD_REFRESH, 2 + seed[4:0], 12);
        ctl.drive(1'b1, CMD_REFRESH, 1);
        ctl.drive(1'b1, CMD_NOP, RFC_CYC + 2);
      end else begin
        allBanksIdle = seed[8];
        ctl.visit(CMD_NOP, 2 + seed[3:0], 6);
        allBanksIdle = 1'b1;
      end
    end
    // Refused requests: power-down while busy, a command in the exit wait.
    accessBusy = 1'b1;
    ctl.drive(1'b0, CMD_NOP, 3);
    ctl.drive(1'b1, CMD_NOP, 4);
    accessBusy = 1'b0;
    ctl.visit(CMD_NOP, 2, 1);
    ctl.drive(1'b1, CMD_REFRESH, 1);
    ctl.drive(1'b1, CMD_NOP, 4);
    ctl.visit(CMD_BURST_END, 4, 8);
    // Deep power-down loses data; a second reset starts the die afresh.
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    ctl.drive(1'b1, CMD_NOP, 6);
    endOfTest();
  end
endmodule : lpc_power_ctrl_bench
`default_nettype wire

// ==== verilog/lpc_pkg.sv ====
/*
  Package for the low-power state control of a low-power DDR memory die.
  Holds command encodings, state encodings, timing constants and carriers.
  Assumes a single 50 MHz system clock that stands for the memory clock.
*/
package lpc_pkg;

  // Clock period in picoseconds, so that fractional ns figures stay exact.
  localparam int CLK_PERIOD_PS = 20000;

  // Timing figures in their own units, with derived cycle counts.
  localparam int SELF_REFRESH_EXIT_DELAY_NS = 120;
  localparam int REFRESH_CYCLE_TIME_NS      = 75;
  localparam int INPUT_SETUP_TIME_PS        = 1500;
  localparam int MIN_LOW_PULSE_CYCLES       = 2;
  localparam int INTERNAL_REFRESH_NS        = 75;
  localparam int AVG_REFRESH_INTERVAL_NS    = 7800;
  localparam int REFRESH_ROWS               = 8192;
  localparam int REFRESH_WINDOW_MS          = 64;
  localparam int MAX_POSTED_REFRESH         = 8;

  // Least times round up to whole cycles.
  localparam int SRX_CYC =
    (SELF_REFRESH_EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_CYC =
    (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int XP_CYC =
    (CLK_PERIOD_PS + INPUT_SETUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IREF_CYC =
    (INTERNAL_REFRESH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Internal self refresh timer reload value, one cycle less than its period (longest time rounds down).
  localparam int REFI_CYC = (AVG_REFRESH_INTERVAL_NS * 1000) / CLK_PERIOD_PS;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // Command pins, active-low chip select and strobes.
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } lpc_cmd_t;

  localparam logic [3:0] CMD_NOP       = 4'h7;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_BURST_END = 4'h6;

  // Device power state.
  typedef enum logic [2:0] {
    ST_NORMAL  = 3'b000,
    ST_PDOWN   = 3'b001,
    ST_SELFREF = 3'b010,
    ST_DEEPPD  = 3'b011,
    ST_EXITWT  = 3'b100
  } lpc_state_t;

  // Status carried to the datapath of the die.
  typedef struct packed {
    logic bufEnable;
    logic intClkEnable;
    logic pumpsOn;
    logic dataLost;
    logic activePd;
    logic illegal;
  } lpc_status_t;

endpackage : lpc_pkg

// ==== verilog/lpc_power_ctrl.sv ====
/*
  Low-power state control of a low-power DDR die: self refresh, power-down,
  deep power-down, exit delays and the internal self refresh timer.
  Assumes clk_sys is the memory clock and pins come from the controller.
*/
`timescale 1ns/1ns
`default_nettype none
module lpc_power_ctrl
  import lpc_pkg::*;
#(
  parameter int REFI_CYCLES = REFI_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ckePin,
  input  wire lpc_cmd_t    cmdPin,
  input  wire logic        allBanksIdle,
  input  wire logic        accessBusy,
  output var  lpc_status_t status,
  output var  lpc_state_t  powerState,
  output var  logic        intRefreshPulse,
  output var  logic        cmdAccept
);

  logic       cke;
  logic [3:0] cmdSync;
  logic       ckePrev_q, ckePrev_d;
  lpc_state_t state_q, state_d;
  logic [CNT_W-1:0] exitCnt_q, exitCnt_d;
  logic [CNT_W-1:0] refCnt_q, refCnt_d;
  logic       refPulse_d;
  logic       accept_d;
  lpc_status_t status_d;
  logic [3:0] cmdNow;
  logic       isNop;

  // Pin levels are foreign to this clock, so every pin is synchronised.
  lpc_sync uCke (.clk_sys(clk_sys), .rst(rst), .pinIn(ckePin),
                 .syncOut(cke));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gCmd
      lpc_sync uCmd (.clk_sys(clk_sys), .rst(rst), .pinIn(cmdPin[gi]),
                     .syncOut(cmdSync[gi]));
    end
  endgenerate
  assign cmdNow   = cmdSync;
  // Deselect (chip select high) counts as a NOP.
  assign isNop = cmdNow[3] || (cmdNow == CMD_NOP);

  // Next-state logic of the power state machine and its counters.
  always_comb begin
    state_d    = state_q;
    ckePrev_d  = cke;
    exitCnt_d  = (exitCnt_q != CNT_ZERO) ? exitCnt_q - 16'h0001 : CNT_ZERO;
    refCnt_d   = refCnt_q;
    refPulse_d = 1'b0;
    accept_d   = 1'b0;
    status_d   = status;
    status_d.illegal = 1'b0;
    case (state_q)
      ST_NORMAL: begin
        status_d.bufEnable    = 1'b1;
        status_d.intClkEnable = 1'b1;
        accept_d = ckePrev_q && cke && !isNop;
        if (ckePrev_q && !cke) begin
          if (!cmdNow[3] && cmdNow == CMD_REFRESH && allBanksIdle) begin
            state_d    = ST_SELFREF;
            refPulse_d = 1'b1;
            refCnt_d   = CNT_W'(REFI_CYCLES);
            status_d.intClkEnable = 1'b0;
            status_d.bufEnable    = 1'b0;
          end else if (!cmdNow[3] && cmdNow == CMD_BURST_END
                       && allBanksIdle) begin
            state_d = ST_DEEPPD;
            status_d.pumpsOn   = 1'b0;
            status_d.dataLost  = 1'b1;
            status_d.bufEnable = 1'b0;
          end else if (isNop && !accessBusy) begin
            state_d = ST_PDOWN;
            status_d.activePd  = !allBanksIdle;
            status_d.bufEnable = 1'b0;
          end else begin
            status_d.illegal = 1'b1;
          end
        end else if (!ckePrev_q && !cke) begin
          status_d.illegal = 1'b1;
        end
      end
      ST_PDOWN: begin
        // Inputs other than clock-enable are ignored while it stays low; exit needs a NOP.
        if (cke) begin
          if (isNop) begin
            state_d   = ST_EXITWT;
            exitCnt_d = CNT_W'(XP_CYC);
            status_d.bufEnable = 1'b1;
            status_d.activePd  = 1'b0;
          end else begin
            status_d.illegal = 1'b1;
          end
        end
      end
      ST_SELFREF: begin
        // Internal timer keeps refreshing, counting clk_sys cycles.
        if (refCnt_q == CNT_ZERO) begin
          refPulse_d = 1'b1;
          refCnt_d   = CNT_W'(REFI_CYCLES);
        end else begin
          refCnt_d = refCnt_q - 16'h0001;
        end
        if (cke) begin
          if (isNop) begin
            state_d   = ST_EXITWT;
            exitCnt_d = CNT_W'(SRX_CYC);
            status_d.intClkEnable = 1'b1;
            status_d.bufEnable    = 1'b1;
          end else begin
            status_d.illegal = 1'b1;
          end
        end
      end
      ST_DEEPPD: begin
        // Exit needs only the enable level, any command is accepted.
        if (cke) begin
          state_d = ST_NORMAL;
          status_d.pumpsOn   = 1'b1;
          status_d.bufEnable = 1'b1;
        end
      end
      ST_EXITWT: begin
        if (!isNop) begin
          status_d.illegal = 1'b1;
        end
        if (exitCnt_q <= 16'h0001) begin
          state_d = ST_NORMAL;
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
  end

  // Registers only; reset brings the die to normal, data valid.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q         <= ST_NORMAL;
      ckePrev_q       <= 1'b0;
      exitCnt_q       <= CNT_ZERO;
      refCnt_q        <= CNT_ZERO;
      intRefreshPulse <= 1'b0;
      cmdAccept       <= 1'b0;
      powerState      <= ST_NORMAL;
      status          <= '{bufEnable: 1'b1, intClkEnable: 1'b1,
                           pumpsOn: 1'b1, dataLost: 1'b0,
                           activePd: 1'b0, illegal: 1'b0};
    end else begin
      state_q         <= state_d;
      ckePrev_q       <= ckePrev_d;
      exitCnt_q       <= exitCnt_d;
      refCnt_q        <= refCnt_d;
      intRefreshPulse <= refPulse_d;
      cmdAccept       <= accept_d;
      powerState      <= state_d;
      status          <= status_d;
    end
  end

  // Checks on the state machine against its causes.
  srEntry_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_NORMAL && ckePrev_q && !cke && cmdNow == CMD_REFRESH
     && allBanksIdle) |=> state_q == ST_SELFREF && intRefreshPulse)
    else $error("self refresh entry missed");
  srClockOff_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SELFREF |-> !status.intClkEnable)
    else $error("clock not gated in self refresh");
  srHold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_SELFREF && !cke) |=> state_q == ST_SELFREF)
    else $error("self refresh left with enable low");
  srExit_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_SELFREF && cke && isNop) |=>
      state_q == ST_EXITWT ##6 state_q == ST_NORMAL)
    else $error("self refresh exit delay wrong");
  pdKind_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_NORMAL && ckePrev_q && !cke && isNop && !accessBusy
     && !allBanksIdle) |=> state_q == ST_PDOWN && status.activePd)
    else $error("active power-down not flagged");
  pdBuf_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_PDOWN |-> !status.bufEnable)
    else $error("buffers on in power-down");
  pdExit_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_PDOWN && cke && isNop) |=>
      state_q == ST_EXITWT ##2 state_q == ST_NORMAL)
    else $error("power-down exit timing wrong");
  dpdEntry_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_NORMAL && ckePrev_q && !cke && cmdNow == CMD_BURST_END
     && allBanksIdle) |=> status.dataLost && !status.pumpsOn)
    else $error("deep power-down entry wrong");
  dpdExit_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_DEEPPD && cke) |=> state_q == ST_NORMAL)
    else $error("deep power-down exit missed");
  exitNop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_EXITWT && !isNop) |=> status.illegal)
    else $error("command in exit delay not flagged");

  srCov: cover property (@(posedge clk_sys) state_q == ST_SELFREF);
  pdCov: cover property (@(posedge clk_sys) state_q == ST_PDOWN);
  dpdCov: cover property (@(posedge clk_sys) state_q == ST_DEEPPD);
  exCov: cover property (@(posedge clk_sys)
    state_q == ST_EXITWT ##1 state_q == ST_NORMAL);

endmodule : lpc_power_ctrl
`default_nettype wire

// ==== verilog/lpc_sync.sv ====
/*
  Two-flop synchroniser for one pin level.
  Assumes the pin is asynchronous to clk_sys; the first flop feeds only
  the second. Both flops reset high, the idle level of clock-enable and of
  a deselected command bus.
*/
`timescale 1ns/1ns
`default_nettype none
module lpc_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pinIn,
  output var  logic syncOut
);
  logic meta_q;

  // Plain two-stage chain; nothing reads the first stage but the second.
  // Resetting high avoids a false low-low enable sample right after reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q  <= 1'b1;
      syncOut <= 1'b1;
    end else begin
      meta_q  <= pinIn;
      syncOut <= meta_q;
    end
  end
endmodule : lpc_sync
`default_nettype wire
